// ===== logic/rpt_host.sv
/*
 * host end: makes the pixel clock by dividing mclk, runs the line
 * and frame counters, packs pixels by bus mode, and sequences the
 * panel hardware reset with the waits that follow it.
 * assumes the pixel source can answer pix_take_o in the same cycle.
 */
`timescale 1ns/100ps
module rpt_host
   import rpt_pkg::*;
#(
   parameter int unsigned PCLK_DIV = PCLK_DIV_DEF,
   parameter int unsigned LSYNC = LSYNC_DEF,
   parameter int unsigned LBP = LBP_DEF,
   parameter int unsigned LACT = LACT_DEF,
   parameter int unsigned LFP = LFP_DEF,
   parameter int unsigned FSYNC = FSYNC_DEF,
   parameter int unsigned FBP = FBP_DEF,
   parameter int unsigned FACT = FACT_DEF,
   parameter int unsigned FFP = FFP_DEF,
   parameter int unsigned CMD_WAIT = CMD_WAIT_CYC,
   parameter int unsigned SLEEP_WAIT = SLEEP_WAIT_CYC
) (
   // link
   rpt_if.host lnk,

   // clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,

   // pixel source
   input wire logic [23:0] pix_i,
   input wire rpt_bus_mode_t mode_i,
   output logic pix_take_o,
   output logic frame_start_o,

   // panel reset control
   input wire logic reset_req_i,
   output logic cmd_ok_o,
   output logic sleep_exit_ok_o
);

   ////////////////////////////////////////////////////////////////////
   // derived timing

   localparam int unsigned HALF = PCLK_DIV / 2;
   localparam int unsigned H_TOT = LSYNC + LBP + LACT + LFP;
   localparam int unsigned V_TOT = FSYNC + FBP + FACT + FFP;
   localparam int unsigned H_A0 = LSYNC + LBP;
   localparam int unsigned H_A1 = LSYNC + LBP + LACT;
   localparam int unsigned V_A0 = FSYNC + FBP;
   localparam int unsigned V_A1 = FSYNC + FBP + FACT;

   ////////////////////////////////////////////////////////////////////
   // declarations

   logic [15:0] div_q;
   logic pclk_q;
   logic fall_tick;

   logic [11:0] h_q;
   logic [11:0] v_q;
   logic [11:0] h_d;
   logic [11:0] v_d;
   logic act_d;

   logic lsync_n_q;
   logic fsync_n_q;
   logic valid_q;
   logic [23:0] bus_q;
   logic frm_q;

   rpt_host_st_t st_q;
   logic [31:0] cnt_q;
   logic rst_n_q;
   logic cmd_ok_q;
   logic slp_ok_q;

   ////////////////////////////////////////////////////////////////////
   // pixel clock divider; outputs change on the falling edge so that
   // they are steady when the panel samples on the rising edge

   assign fall_tick = (div_q == 16'(PCLK_DIV - 1));

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_q <= '0;
      end else if (fall_tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 16'd1;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pclk_q <= 1'b0;
      end else if (div_q == 16'(HALF - 1)) begin
         pclk_q <= 1'b1;
      end else if (fall_tick) begin
         pclk_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // line and frame counters; counts are fixed parameters, so every
   // frame has the same length

   always_comb begin
      if (h_q == 12'(H_TOT - 1)) begin
         h_d = '0;
         if (v_q == 12'(V_TOT - 1)) begin
            v_d = '0;
         end else begin
            v_d = v_q + 12'd1;
         end
      end else begin
         h_d = h_q + 12'd1;
         v_d = v_q;
      end
   end

   assign act_d = (h_d >= 12'(H_A0)) && (h_d < 12'(H_A1)) &&
                  (v_d >= 12'(V_A0)) && (v_d < 12'(V_A1));

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         h_q <= 12'(H_TOT - 1);
         v_q <= 12'(V_TOT - 1);
      end else if (fall_tick) begin
         h_q <= h_d;
         v_q <= v_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sync pulses and data enable

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lsync_n_q <= 1'b1;
         fsync_n_q <= 1'b1;
         valid_q <= 1'b0;
      end else if (fall_tick) begin
         lsync_n_q <= !(h_d < 12'(LSYNC));
         fsync_n_q <= !(v_d < 12'(FSYNC));
         valid_q <= act_d;
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frm_q <= 1'b0;
      end else begin
         frm_q <= fall_tick && (h_d == '0) && (v_d == '0);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pixel packing; narrow modes keep the top bits of each colour
   // and leave the unused high lines of the bus at zero

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         bus_q <= '0;
      end else if (fall_tick) begin
         if (!act_d) begin
            bus_q <= '0;
         end else begin
            unique case (mode_i)
               RPT_BUS24: bus_q <= pix_i;
               RPT_BUS18: bus_q <= {6'h00, pix_i[23:18],
                                    pix_i[15:10], pix_i[7:2]};
               RPT_BUS16: bus_q <= {8'h00, pix_i[23:19],
                                    pix_i[15:10], pix_i[7:3]};
               default: bus_q <= pix_i;
            endcase
         end
      end
   end

   // one pixel consumed per pixel clock in the active area
   assign pix_take_o = fall_tick && act_d;

   ////////////////////////////////////////////////////////////////////
   // panel reset sequence: hold low, then time the command waits

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q <= HST_DRIVE;
         cnt_q <= '0;
      end else if (reset_req_i) begin
         st_q <= HST_DRIVE;
         cnt_q <= '0;
      end else begin
         unique case (st_q)
            HST_DRIVE: begin
               if (cnt_q == 32'(RST_HOLD_CYC - 1)) begin
                  st_q <= HST_SETTLE;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + 32'd1;
               end
            end
            HST_SETTLE: begin
               if (cnt_q == SLEEP_WAIT - 1) begin
                  st_q <= HST_READY;
               end else begin
                  cnt_q <= cnt_q + 32'd1;
               end
            end
            HST_READY: begin
               cnt_q <= cnt_q;
            end
         endcase
      end
   end

   // the line is low from power-up, so the panel always sees a reset
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_n_q <= 1'b0;
      end else begin
         rst_n_q <= !reset_req_i && (st_q != HST_DRIVE);
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_ok_q <= 1'b0;
         slp_ok_q <= 1'b0;
      end else if (reset_req_i || st_q == HST_DRIVE) begin
         cmd_ok_q <= 1'b0;
         slp_ok_q <= 1'b0;
      end else begin
         // cnt_q leads the rise of the line by one edge
         cmd_ok_q <= (st_q == HST_READY) ||
                     (cnt_q >= CMD_WAIT);
         slp_ok_q <= (st_q == HST_READY);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   assign lnk.pixel_clock = pclk_q;
   assign lnk.line_sync_n = lsync_n_q;
   assign lnk.frame_sync_n = fsync_n_q;
   assign lnk.pixel_valid = valid_q;
   assign lnk.pixel_bus = bus_q;
   assign lnk.hw_reset_n = rst_n_q;

   assign frame_start_o = frm_q;
   assign cmd_ok_o = cmd_ok_q;
   assign sleep_exit_ok_o = slp_ok_q;

endmodule : rpt_host

// ===== pkg/rpt_pkg.sv
/*
 * constants and types shared by both ends of the rgb panel link:
 * cycle counts for reset filtering and waits, default video timing,
 * bus-width modes and state enumerations.
 * assumes a 25 mhz mclk on both ends.
 */
// Functional notes
// - host keeps 54-66 fps, 16.6-41.7 mhz clock; defaults give 3.125 mhz, about 7 fps
// - line: sync>=1, porch 2-126, 480 active, fp>=2
// - frame: sync 1-126, bp 1-126, <=864, fp 1-255
// - pixel bus carries 24, 18 or 16 bits
// - reject <5us reset, accept >9us; host holds 10us
// - glitches inside valid reset are filtered too
// - reload settings after release: 5ms/120ms
// - blank during reset, then default state
// - host waits 5ms before any command
// - no sleep exit before 120ms after release
// - host drives line and frame sync
package rpt_pkg;

   ////////////////////////////////////////////////////////////////////
   // clock
   localparam int unsigned MCLK_NS = 40;

   ////////////////////////////////////////////////////////////////////
   // reset timing, in ns as specified, then in mclk cycles
   localparam int unsigned RST_REJECT_NS = 5000;
   localparam int unsigned RST_ACCEPT_NS = 9000;
   localparam int unsigned RST_HOLD_NS = 10000;
   localparam int unsigned CMD_WAIT_NS = 5000000;
   localparam int unsigned SLEEP_WAIT_NS = 120000000;
   localparam int unsigned LOAD_IN_NS = 5000000;
   localparam int unsigned LOAD_OUT_NS = 120000000;

   // least times round up, longest times round down
   localparam int unsigned RST_FILT_CYC =
      (RST_REJECT_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int unsigned RST_ACCEPT_CYC = RST_ACCEPT_NS / MCLK_NS;
   localparam int unsigned RST_HOLD_CYC =
      (RST_HOLD_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int unsigned CMD_WAIT_CYC =
      (CMD_WAIT_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int unsigned SLEEP_WAIT_CYC =
      (SLEEP_WAIT_NS + MCLK_NS - 1) / MCLK_NS;
   localparam int unsigned LOAD_IN_CYC = LOAD_IN_NS / MCLK_NS;
   localparam int unsigned LOAD_OUT_CYC = LOAD_OUT_NS / MCLK_NS;

   ////////////////////////////////////////////////////////////////////
   // default video timing: pixel clock divider in mclk cycles, then pixel clocks and lines
   localparam int unsigned PCLK_DIV_DEF = 8;
   localparam int unsigned LSYNC_DEF = 4;
   localparam int unsigned LBP_DEF = 8;
   localparam int unsigned LACT_DEF = 480;
   localparam int unsigned LFP_DEF = 8;
   localparam int unsigned FSYNC_DEF = 2;
   localparam int unsigned FBP_DEF = 4;
   localparam int unsigned FACT_DEF = 854;
   localparam int unsigned FFP_DEF = 4;

   ////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      RPT_BUS24,
      RPT_BUS18,
      RPT_BUS16
   } rpt_bus_mode_t;

   typedef enum logic [1:0] {
      HST_DRIVE,
      HST_SETTLE,
      HST_READY
   } rpt_host_st_t;

   typedef enum logic [1:0] {
      PNL_RESET,
      PNL_LOAD,
      PNL_RUN
   } rpt_panel_st_t;

endpackage : rpt_pkg

// ===== pkg/rpt_if.sv
/*
 * pixel port and hardware reset line between host and panel.
 * assumes the bench connects one host and one panel instance.
 */
`timescale 1ns/100ps
interface rpt_if;
   logic pixel_clock;
   logic line_sync_n;
   logic frame_sync_n;
   logic pixel_valid;
   logic [23:0] pixel_bus;
   logic hw_reset_n;

   modport host (
      output pixel_clock,
      output line_sync_n,
      output frame_sync_n,
      output pixel_valid,
      output pixel_bus,
      output hw_reset_n
   );

   modport panel (
      input pixel_clock,
      input line_sync_n,
      input frame_sync_n,
      input pixel_valid,
      input pixel_bus,
      input hw_reset_n
   );
endinterface : rpt_if

// ===== logic/rpt_sync2.sv
/*
 * two-flop synchroniser for a group of link pins.
 * assumes each bit is stable long enough to be sampled alone.
 */
`timescale 1ns/100ps
module rpt_sync2 #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // data
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule : rpt_sync2

// ===== logic/rpt_panel.sv
/*
 * panel end: filters the hardware reset line, blanks and reloads
 * settings after reset, and captures pixels on pixel clock edges.
 * assumes the pixel clock is well below mclk / 4.
 */
`timescale 1ns/100ps
module rpt_panel
   import rpt_pkg::*;
#(
   parameter int unsigned LOAD_IN = LOAD_IN_CYC,
   parameter int unsigned LOAD_OUT = LOAD_OUT_CYC
) (
   // link
   rpt_if.panel lnk,
   // clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // mode
   input wire rpt_bus_mode_t mode_i,
   input wire logic sleep_out_i,
   // pixel sink
   output logic [23:0] pix_o,
   output logic pix_valid_o,
   output logic line_start_o,
   output logic frame_start_o,
   // status
   output logic blank_o,
   output logic loading_o,
   output logic ready_o
);
   logic [28:0] s;
   logic rst_s, pclk_s, lsync_s, fsync_s, valid_s;
   logic [23:0] bus_s;
   logic filt_q;
   logic [7:0] filt_cnt_q;
   rpt_panel_st_t st_q;
   logic [31:0] load_cnt_q;
   logic slp_out_q;
   logic pclk_p_q, lsync_p_q, fsync_p_q;
   logic rise, run, live;
   logic [23:0] pix_q;
   logic valid_q, lstart_q, fstart_q;

   rpt_sync2 #(.W(29)) u_sync (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .d_i({lnk.hw_reset_n, lnk.pixel_clock, lnk.line_sync_n,
            lnk.frame_sync_n, lnk.pixel_valid, lnk.pixel_bus}),
      .q_o(s)
   );
   assign {rst_s, pclk_s, lsync_s, fsync_s, valid_s, bus_s} = s;

   ////////////////////////////////////////////////////////////////////
   // reset filter: a level must persist before it is believed, both
   // going into reset and coming out of it
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         filt_q <= 1'b0;
         filt_cnt_q <= '0;
      end else if (rst_s == filt_q) begin
         filt_cnt_q <= '0;
      end else if (filt_cnt_q == 8'(RST_FILT_CYC - 1)) begin
         filt_q <= rst_s;
         filt_cnt_q <= '0;
      end else begin
         filt_cnt_q <= filt_cnt_q + 8'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // reset, reload and run sequence
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_q <= PNL_RESET;
         load_cnt_q <= '0;
      end else begin
         unique case (st_q)
            PNL_RESET: begin
               load_cnt_q <= '0;
               if (filt_q) begin
                  st_q <= PNL_LOAD;
               end
            end
            PNL_LOAD: begin
               load_cnt_q <= load_cnt_q + 32'd1;
               if (!filt_q) begin
                  st_q <= PNL_RESET;
               end else if (load_cnt_q == (slp_out_q ? LOAD_OUT - 1 :
                                           LOAD_IN - 1)) begin
                  st_q <= PNL_RUN;
               end
            end
            PNL_RUN: begin
               if (!filt_q) begin
                  st_q <= PNL_RESET;
               end
            end
         endcase
      end
   end

   // sleep mode at the moment reset starts picks the reload time
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         slp_out_q <= 1'b0;
      end else if (st_q != PNL_RESET && !filt_q) begin
         slp_out_q <= sleep_out_i;
      end
   end

   assign run = (st_q == PNL_RUN);
   assign blank_o = !run;
   assign loading_o = (st_q == PNL_LOAD);
   assign ready_o = run;
   // a pixel on the edge that leaves run is dropped, so no valid
   // pulse ever shows while blank
   assign live = run && filt_q;

   ////////////////////////////////////////////////////////////////////
   // pixel capture on rising pixel clock edges
   assign rise = pclk_s && !pclk_p_q;

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pclk_p_q <= 1'b0;
         lsync_p_q <= 1'b1;
         fsync_p_q <= 1'b1;
      end else begin
         pclk_p_q <= pclk_s;
         if (rise) begin
            lsync_p_q <= lsync_s;
            fsync_p_q <= fsync_s;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         valid_q <= 1'b0;
         lstart_q <= 1'b0;
         fstart_q <= 1'b0;
      end else begin
         valid_q <= rise && live && valid_s;
         lstart_q <= rise && live && lsync_p_q && !lsync_s;
         fstart_q <= rise && live && fsync_p_q && !fsync_s;
      end
   end

   // narrow modes widen by repeating the top bits of each colour
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pix_q <= '0;
      end else if (!live) begin
         pix_q <= '0;
      end else if (rise && valid_s) begin
         unique case (mode_i)
            RPT_BUS24: pix_q <= bus_s;
            RPT_BUS18: pix_q <= {bus_s[17:12], bus_s[17:16],
                                 bus_s[11:6], bus_s[11:10],
                                 bus_s[5:0], bus_s[5:4]};
            RPT_BUS16: pix_q <= {bus_s[15:11], bus_s[15:13],
                                 bus_s[10:5], bus_s[10:9],
                                 bus_s[4:0], bus_s[4:2]};
            default: pix_q <= bus_s;
         endcase
      end
   end

   assign pix_o = pix_q;
   assign pix_valid_o = valid_q;
   assign line_start_o = lstart_q;
   assign frame_start_o = fstart_q;
endmodule : rpt_panel

// ===== dv/rpt_link_monitor.sv
/*
 * checker on the pixel link between host and panel.
 * assumes a pixel clock of 8 mclk, high for the second half.
 */
`timescale 1ns/100ps
module rpt_link_monitor #(
   parameter int LSYNC = 4,
   parameter int LACT = 480,
   parameter int LTOT = 500
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic arst_n_i,
   // link
   input wire logic pixel_clock,
   input wire logic line_sync_n,
   input wire logic frame_sync_n,
   input wire logic pixel_valid,
   input wire logic [23:0] pixel_bus,
   input wire logic hw_reset_n
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);

   ////////////////////////////////////////////////////////////////////
   logic pc_q;
   logic ls_q;
   logic seen_q;
   int tot_q;
   int act_q;
   int syn_q;
   int low_q;
   wire logic lfall = ls_q && !line_sync_n;
   wire logic prise = pixel_clock && !pc_q;

   // line length, activity and sync width checks start only after a line start, the first line is partial
   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pc_q <= 1'b0;
         ls_q <= 1'b1;
         seen_q <= 1'b0;
         tot_q <= 0;
         act_q <= 0;
         syn_q <= 0;
      end else begin
         pc_q <= pixel_clock;
         ls_q <= line_sync_n;
         if (lfall) begin
            seen_q <= 1'b1;
            tot_q <= 0;
            act_q <= 0;
            syn_q <= 0;
         end else if (prise) begin
            tot_q <= tot_q + 1;
            act_q <= act_q + int'(pixel_valid);
            syn_q <= syn_q + int'(!line_sync_n);
         end
      end
   end

   always_ff @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_q <= 0;
      end else if (hw_reset_n) begin
         low_q <= 0;
      end else if (low_q < 1000) begin
         low_q <= low_q + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   property p_bus_idle;
      !pixel_valid |-> pixel_bus == 24'h00_0000;
   endproperty
   a_bus_idle: assert property (p_bus_idle)
      else $error("pixel bus not zero outside active area");
   property p_valid_on_fall;
      $changed(pixel_valid) |-> $fell(pixel_clock);
   endproperty
   a_valid_on_fall: assert property (p_valid_on_fall)
      else $error("pixel valid moved off a pixel clock fall");
   property p_lsync_on_fall;
      $changed(line_sync_n) |-> $fell(pixel_clock);
   endproperty
   a_lsync_on_fall: assert property (p_lsync_on_fall)
      else $error("line sync moved off a pixel clock fall");
   property p_fsync_on_line;
      $changed(frame_sync_n) |-> $fell(line_sync_n);
   endproperty
   a_fsync_on_line: assert property (p_fsync_on_line)
      else $error("frame sync moved away from a line start");
   property p_clk_high;
      $rose(pixel_clock) |-> pixel_clock [*4] ##1 !pixel_clock;
   endproperty
   a_clk_high: assert property (p_clk_high)
      else $error("pixel clock high phase wrong");
   property p_line_len;
      seen_q && lfall |-> tot_q == LTOT;
   endproperty
   a_line_len: assert property (p_line_len)
      else $error("line length wrong");
   property p_line_act;
      seen_q && lfall |-> act_q == LACT || act_q == 0;
   endproperty
   a_line_act: assert property (p_line_act)
      else $error("active pixel count wrong");
   property p_sync_w;
      seen_q && $rose(line_sync_n) |-> syn_q == LSYNC;
   endproperty
   a_sync_w: assert property (p_sync_w)
      else $error("line sync width wrong");
   property p_rst_hold;
      $rose(hw_reset_n) |-> low_q >= 249;
   endproperty
   a_rst_hold: assert property (p_rst_hold)
      else $error("panel reset held too briefly");

   c_active: cover property ($rose(pixel_valid));
   c_release: cover property ($rose(hw_reset_n));
   c_frame: cover property ($fell(frame_sync_n));
endmodule : rpt_link_monitor

// ===== dv/test_rgb_panel_timing_and_reset.sv
/*
 * testbench: host and panel face each other; a second panel is
 * driven by the bench with reset glitches.
 * assumes the rpt package, interface and both ends compiled first.
 */
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module test_rgb_panel_timing_and_reset;
   import rpt_pkg::*;
   localparam int LS = 4, LB = 8, LA = 480, LF = 8;
   localparam int FA = 2, CW = 50, SW = 200, LI = 40, LO = 80;
   logic mclk_i, arst_n_i, reset_req_i, sleep_out_i;
   logic [23:0] pix_i, pix_o, exp_v, raw_d;
   rpt_bus_mode_t mode_q;
   logic pix_take_o, hframe, cmd_ok_o, sx_ok, tk_d;
   logic pix_valid_o, blank_o, loading_o, ready_o, blank2, ready2;
   logic [31:0] rnd_q;
   logic [23:0] exp_q[$];
   int err_total, total_checks, takes;

   rpt_if lnk();
   rpt_if lnk2();
   rpt_host #(.PCLK_DIV(8), .LSYNC(LS), .LBP(LB), .LACT(LA), .LFP(LF),
      .FSYNC(1), .FBP(1), .FACT(FA), .FFP(1), .CMD_WAIT(CW),
      .SLEEP_WAIT(SW)) i_rpt_host (.lnk(lnk.host), .mclk_i(mclk_i),
      .arst_n_i(arst_n_i), .pix_i(pix_i), .mode_i(mode_q),
      .pix_take_o(pix_take_o), .frame_start_o(hframe),
      .reset_req_i(reset_req_i), .cmd_ok_o(cmd_ok_o),
      .sleep_exit_ok_o(sx_ok));
   rpt_panel #(.LOAD_IN(LI), .LOAD_OUT(LO)) i_rpt_panel (
      .lnk(lnk.panel), .mclk_i(mclk_i), .arst_n_i(arst_n_i),
      .mode_i(mode_q), .sleep_out_i(sleep_out_i), .pix_o(pix_o),
      .pix_valid_o(pix_valid_o), .line_start_o(), .frame_start_o(),
      .blank_o(blank_o), .loading_o(loading_o), .ready_o(ready_o));
   rpt_panel #(.LOAD_IN(LI), .LOAD_OUT(LO)) i_rpt_panel_2 (
      .lnk(lnk2.panel), .mclk_i(mclk_i), .arst_n_i(arst_n_i),
      .mode_i(RPT_BUS24), .sleep_out_i(1'b0), .pix_o(),
      .pix_valid_o(), .line_start_o(), .frame_start_o(),
      .blank_o(blank2), .loading_o(), .ready_o(ready2));
   rpt_link_monitor #(.LSYNC(LS), .LACT(LA), .LTOT(LS + LB + LA + LF))
      i_rpt_link_monitor (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
      .pixel_clock(lnk.pixel_clock), .line_sync_n(lnk.line_sync_n),
      .frame_sync_n(lnk.frame_sync_n), .pixel_valid(lnk.pixel_valid),
      .pixel_bus(lnk.pixel_bus), .hw_reset_n(lnk.hw_reset_n));

   ////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [23:0] pack(input logic [23:0] p,
                                        input rpt_bus_mode_t m);
      if (m == RPT_BUS18) return {6'h00, p[23:18], p[15:10], p[7:2]};
      if (m == RPT_BUS16) return {8'h00, p[23:19], p[15:10], p[7:3]};
      return p;
   endfunction : pack
   function automatic logic [23:0] widen(input logic [23:0] p,
                                         input rpt_bus_mode_t m);
      if (m == RPT_BUS18) return {p[23:18], p[23:22], p[15:10],
         p[15:14], p[7:2], p[7:6]};
      if (m == RPT_BUS16) return {p[23:19], p[23:21], p[15:10],
         p[15:14], p[7:3], p[7:5]};
      return p;
   endfunction : widen

   task automatic give_verdict();
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   ////////////////////////////////////////////////////////////////////
   always #20 mclk_i = ~mclk_i;

   // the pixel bus of the second link, which no host drives, still toggles
   always @(posedge mclk_i) begin
      rnd_q <= xs(rnd_q);
      pix_i <= rnd_q[23:0];
      lnk2.pixel_bus <= rnd_q[31:8];
   end

   // pixels taken before the panel is ready are not expected back;
   // pop before push, so a pixel caught as the panel wakes is not
   // matched against the one taken in the same cycle
   always @(posedge mclk_i) begin
      if (tk_d) `CHK("pixel_bus", pack(raw_d, mode_q), lnk.pixel_bus)
      tk_d <= pix_take_o;
      raw_d <= pix_i;
      if (blank_o !== 1'b0) begin
         exp_q.delete();
         `CHK("valid_blank", 1'b0, pix_valid_o)
         `CHK("pix_blank", 24'h00_0000, pix_o)
      end else if (pix_valid_o === 1'b1 && exp_q.size() > 0) begin
         exp_v = exp_q.pop_front();
         `CHK("pixel", exp_v, pix_o)
      end
      if (pix_take_o === 1'b1) begin
         takes++;
         if (ready_o === 1'b1) exp_q.push_back(widen(pix_i, mode_q));
      end
   end

   task automatic measure(input int ld);
      int i, cmd_at, sx_at, rdy_at, ld_n;
      cmd_at = -1;
      sx_at = -1;
      rdy_at = -1;
      ld_n = 0;
      for (i = 0; i < 600 && lnk.hw_reset_n !== 1'b1; i++)
         @(negedge mclk_i);
      for (i = 0; i < 400; i++) begin
         @(negedge mclk_i);
         if (cmd_at < 0 && cmd_ok_o === 1'b1) cmd_at = i;
         if (sx_at < 0 && sx_ok === 1'b1) sx_at = i;
         if (rdy_at < 0 && ready_o === 1'b1) rdy_at = i;
         if (loading_o === 1'b1) ld_n++;
      end
      `CHK("cmd_wait", 1'b1, cmd_at >= CW - 2 && cmd_at <= CW + 2)
      `CHK("sleep_wait", 1'b1, sx_at >= SW - 2 && sx_at <= SW + 2)
      `CHK("load_len", 1'b1, ld_n >= ld - 1 && ld_n <= ld + 1)
      `CHK("ready_at", 1'b1, rdy_at >= 124 + ld && rdy_at <= 134 + ld)
   endtask : measure

   task automatic rst_req(input logic so);
      int n;
      @(posedge mclk_i);
      sleep_out_i <= so;
      reset_req_i <= 1'b1;
      @(posedge mclk_i);
      reset_req_i <= 1'b0;
      for (n = 0; n < 20 && lnk.hw_reset_n !== 1'b0; n++)
         @(negedge mclk_i);
      for (n = 0; n < 200 && blank_o !== 1'b1; n++) @(negedge mclk_i);
      `CHK("blank_at", 1'b1, n >= 120 && n <= 132)
      `CHK("ready_blank", 1'b0, ready_o)
      measure(so ? LO : LI);
   endtask : rst_req

   task automatic drv2(input logic v, input int n);
      lnk2.hw_reset_n <= v;
      repeat (n) @(posedge mclk_i);
   endtask : drv2

   initial begin : watchdog
      #(40 * 95000);
      err_total++;
      give_verdict();
   end

   initial begin : main
      int i, t0;
      mclk_i = 1'b0;
      arst_n_i = 1'b0;
      reset_req_i = 1'b0;
      sleep_out_i = 1'b0;
      mode_q = RPT_BUS24;
      rnd_q = 32'h0000_bd14;
      pix_i = 24'h00_0000;
      lnk2.pixel_clock = 1'b0;
      lnk2.line_sync_n = 1'b1;
      lnk2.frame_sync_n = 1'b1;
      lnk2.pixel_valid = 1'b0;
      lnk2.pixel_bus = 24'h00_0000;
      lnk2.hw_reset_n = 1'b0;
      repeat (3) @(posedge mclk_i);
      arst_n_i <= 1'b1;
      measure(LI);
      rst_req(1'b1);
      rst_req(1'b0);
      @(posedge mclk_i);
      drv2(1'b1, 300);
      drv2(1'b0, 100);
      drv2(1'b1, 50);
      `CHK("short_reject", 1'b0, blank2)
      drv2(1'b0, 100);
      drv2(1'b1, 50);
      drv2(1'b0, 150);
      `CHK("glitch_blank", 1'b1, blank2)
      drv2(1'b1, 50);
      drv2(1'b0, 20);
      `CHK("glitch_hold", 1'b1, blank2)
      lnk2.hw_reset_n <= 1'b1;
      for (i = 0; i < 300 && ready2 !== 1'b1; i++) @(negedge mclk_i);
      `CHK("glitch_ready", 1'b1, i >= 124 + LI && i <= 134 + LI)
      t0 = 0;
      for (int m = 0; m < 4; m++) begin
         for (i = 0; i < 25000 && hframe !== 1'b1; i++) @(negedge mclk_i);
         `CHK("frame_start", 1'b1, hframe)
         if (m > 0) `CHK("takes", FA * LA, takes - t0)
         t0 = takes;
         @(posedge mclk_i);
         mode_q <= rpt_bus_mode_t'(m % 3);
         // the pulse still reads high in this time step
         @(negedge mclk_i);
      end
      give_verdict();
   end
endmodule : test_rgb_panel_timing_and_reset
